// ---- verilog/cia_defines.svh ----
// Constants for the gated integrator and serial converter model.
// Assumes a 125 MHz ref_clk; included by the package and the top module.
`ifndef CIA_DEFINES_SVH
`define CIA_DEFINES_SVH

`define CIA_CLK_PERIOD_NS 8
`define CIA_CONV_TIME_NS 800
// Least conversion time rounded up to whole cycles
`define CIA_CONV_CYCLES \
   ((`CIA_CONV_TIME_NS + `CIA_CLK_PERIOD_NS - 1) / `CIA_CLK_PERIOD_NS)
`define CIA_RESULT_BITS 18
`define CIA_RESULT_MSB 17
`define CIA_MIDSCALE 18'h20000
`define CIA_ACC_RESET 24'h000000

`endif

// ---- verilog/cia_pkg.sv ----
// Types shared by the integrator and converter model.
// Assumes cia_defines.svh sits on the include path.
`include "cia_defines.svh"

package cia_pkg;

   // Controller-driven pin levels, synchronised as one group
   typedef struct packed {
      logic integrator_gate;
      logic integrator_discharge;
      logic convert_strobe;
      logic shift_clk;
      logic invert_select;
      logic noninvert_select;
      logic input_clamp;
   } cia_ctrl_t;

   typedef enum logic [1:0] {
      CIA_IDLE = 2'b00,
      CIA_CONVERT = 2'b01,
      CIA_READY = 2'b10,
      CIA_SHIFT = 2'b11
   } cia_state_t;

endpackage

// ---- verilog/cia_integrator_adc.sv ----
// Digital model of the gated CDS integrator and its 18-bit serial converter.
// Assumes control pins come from a controller outside ref_clk's domain and
// video_sample is produced on ref_clk; serial data is an open-drain style pin.
`include "cia_defines.svh"

module cia_integrator_adc
   import cia_pkg::*;
#(
   parameter int ACC_W = 24,
   parameter int CONV_CYCLES = `CIA_CONV_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire cia_ctrl_t ctrl_pins,
   input wire logic signed [15:0] video_sample,
   input wire logic serial_data_i,
   output logic serial_data_o,
   output logic serial_data_oe,
   output logic signed [ACC_W-1:0] integrator_out,
   output logic conv_busy
);

   // Two-stage synchroniser; stage one is read only by stage two
   cia_ctrl_t meta_reg;
   cia_ctrl_t sync_reg;
   cia_ctrl_t sync_next;
   logic strobe_prev_reg;
   logic sclk_prev_reg;
   logic strobe_rise;
   logic sclk_rise;

   always_comb begin
      sync_next = meta_reg;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         meta_reg <= '0;
         sync_reg <= '0;
         strobe_prev_reg <= 1'b0;
         sclk_prev_reg <= 1'b0;
      end else begin
         meta_reg <= ctrl_pins;
         sync_reg <= sync_next;
         strobe_prev_reg <= sync_reg.convert_strobe;
         sclk_prev_reg <= sync_reg.shift_clk;
      end
   end

   assign strobe_rise = sync_reg.convert_strobe & ~strobe_prev_reg;
   assign sclk_rise = sync_reg.shift_clk & ~sclk_prev_reg;

   // Input path: clamp and polarity switches ahead of the integrator.
   // Common mode (both selects) and open mode both present zero input,
   // which stands in for the amplifier parking at its zero point.
   logic signed [ACC_W-1:0] gated_in;
   logic signed [ACC_W-1:0] acc_reg;
   logic signed [ACC_W-1:0] acc_next;

   always_comb begin
      gated_in = '0;
      if (!sync_reg.input_clamp) begin
         if (sync_reg.noninvert_select && !sync_reg.invert_select) begin
            gated_in = ACC_W'(video_sample);
         end else if (sync_reg.invert_select &&
                      !sync_reg.noninvert_select) begin
            gated_in = -ACC_W'(video_sample);
         end
      end
   end

   // Integrator: inverting gain, so the gated input is subtracted
   always_comb begin
      acc_next = acc_reg;
      if (sync_reg.integrator_gate) begin
         acc_next = acc_reg - gated_in;
      end else if (sync_reg.integrator_discharge) begin
         acc_next = '0;
      end
      // Both controls low falls through and holds the output
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         acc_reg <= `CIA_ACC_RESET;
      end else begin
         acc_reg <= acc_next;
      end
   end

   assign integrator_out = acc_reg;

   // Converter sequencer
   cia_state_t state_reg;
   cia_state_t state_next;
   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;
   logic [`CIA_RESULT_MSB:0] shift_reg;
   logic [`CIA_RESULT_MSB:0] shift_next;
   logic [4:0] bit_reg;
   logic [4:0] bit_next;
   logic sdo_reg;
   logic sdo_next;
   logic oe_reg;
   logic oe_next;
   logic [`CIA_RESULT_MSB:0] sample_word;

   // Offset binary of the held integrator value, low bits only
   assign sample_word = acc_reg[`CIA_RESULT_MSB:0] ^ `CIA_MIDSCALE;

   // Strobe edges outside IDLE are ignored: a conversion is never cut short
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      shift_next = shift_reg;
      bit_next = bit_reg;
      sdo_next = sdo_reg;
      oe_next = oe_reg;
      case (state_reg)
         CIA_IDLE: begin
            oe_next = 1'b0;
            sdo_next = 1'b1;
            if (strobe_rise) begin
               shift_next = sample_word;
               cnt_next = 16'(CONV_CYCLES - 1);
               state_next = CIA_CONVERT;
            end
         end
         CIA_CONVERT: begin
            oe_next = 1'b0;
            if (cnt_reg == 16'h0000) begin
               oe_next = 1'b1;
               sdo_next = 1'b0;
               state_next = CIA_READY;
            end else begin
               cnt_next = cnt_reg - 16'h0001;
            end
         end
         CIA_READY: begin
            if (sclk_rise) begin
               sdo_next = shift_reg[`CIA_RESULT_MSB];
               shift_next = {shift_reg[`CIA_RESULT_MSB-1:0], 1'b0};
               bit_next = 5'h01;
               state_next = CIA_SHIFT;
            end
         end
         CIA_SHIFT: begin
            if (sclk_rise) begin
               if (bit_reg == 5'(`CIA_RESULT_BITS)) begin
                  oe_next = 1'b0;
                  sdo_next = 1'b1;
                  state_next = CIA_IDLE;
               end else begin
                  sdo_next = shift_reg[`CIA_RESULT_MSB];
                  shift_next = {shift_reg[`CIA_RESULT_MSB-1:0], 1'b0};
                  bit_next = bit_reg + 5'h01;
               end
            end
         end
         default: begin
            state_next = CIA_IDLE;
            oe_next = 1'b0;
            sdo_next = 1'b1;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_reg <= CIA_IDLE;
         cnt_reg <= 16'h0000;
         shift_reg <= 18'h00000;
         bit_reg <= 5'h00;
         sdo_reg <= 1'b1;
         oe_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         shift_reg <= shift_next;
         bit_reg <= bit_next;
         sdo_reg <= sdo_next;
         oe_reg <= oe_next;
      end
   end

   assign serial_data_o = sdo_reg;
   assign serial_data_oe = oe_reg;
   assign conv_busy = (state_reg == CIA_CONVERT);

   // Helper: conversion length counter for checking
   logic [15:0] chk_conv_reg;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         chk_conv_reg <= 16'h0000;
      end else if (state_reg == CIA_CONVERT) begin
         chk_conv_reg <= chk_conv_reg + 16'h0001;
      end else begin
         chk_conv_reg <= 16'h0000;
      end
   end

   AST_HOLD_WHEN_IDLE: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (!sync_reg.integrator_gate && !sync_reg.integrator_discharge)
      |=> (acc_reg == $past(acc_reg)))
      else $error("Integrator output moved in hold state");

   AST_GATE_RAMPS: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      sync_reg.integrator_gate |=> (acc_reg == $past(acc_reg - gated_in)))
      else $error("Integrator did not follow gated input");

   AST_STROBE_STARTS: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (strobe_rise && state_reg == CIA_IDLE)
      |=> (state_reg == CIA_CONVERT && shift_reg == $past(sample_word)))
      else $error("Conversion did not start on strobe edge");

   AST_CONV_RELEASED: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (state_reg == CIA_CONVERT) |-> (!serial_data_oe && serial_data_o))
      else $error("Data line driven during conversion");

   // Counter holds completed busy cycles, so it is one short in the last
   AST_CONV_LENGTH: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (state_reg == CIA_CONVERT && $past(state_reg) == CIA_CONVERT
       && state_next != CIA_CONVERT)
      |-> (chk_conv_reg == 16'(CONV_CYCLES - 1)))
      else $error("Conversion length wrong");

   AST_EOC_LOW: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (state_reg == CIA_CONVERT && cnt_reg == 16'h0000)
      |=> (serial_data_oe && !serial_data_o)
          throughout (state_reg == CIA_READY) [*1])
      else $error("End of conversion not signalled low");

   AST_BIT_PER_CLOCK: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (sclk_rise && state_reg == CIA_READY)
      |=> (serial_data_o == $past(shift_reg[`CIA_RESULT_MSB])
           && bit_reg == 5'h01))
      else $error("First shifted bit is not the MSB");

   AST_EIGHTEEN_BITS: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (state_reg == CIA_SHIFT) |-> (bit_reg <= 5'(`CIA_RESULT_BITS)))
      else $error("More than eighteen bits shifted");

endmodule // cia_integrator_adc

// ---- dv/cia_ctrl_model.sv ----
// Controller model: sequences a CDS pixel, its video levels and readout.
// Assumes the bench resolves the pulled-up data pin onto serial_pin.
module cia_ctrl_model
   import cia_pkg::*;
#(
   parameter int DISCH = 8,
   parameter int SETTLE = 4
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [7:0] dwell,
   input wire logic signed [15:0] level_a,
   input wire logic signed [15:0] level_b,
   input wire logic serial_pin,
   output cia_ctrl_t ctrl_pins,
   output logic signed [15:0] video,
   output logic [17:0] pixel,
   output logic done
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [17:0] word;
   int n;

   // Drive one pin pattern for a number of cycles
   task automatic hold(input logic [6:0] v, input int cyc);
      ctrl_pins <= cia_ctrl_t'(v);
      repeat (cyc) @(posedge ref_clk);
   endtask

   // One pixel per start; shift clock stands low between frames
   initial begin
      ctrl_pins = '0;
      video = '0;
      pixel = '0;
      done = 1'b1;
      forever begin
         @(posedge ref_clk);
         if (rst_n === 1'b1 && start === 1'b1) begin
            done <= 1'b0;
            hold(7'h27, DISCH);
            video <= level_a;
            hold(7'h44, dwell);
            // Two common-mode cycles keep the second level out of the
            // first integration, which the pin sync delays by two
            hold(7'h06, 2);
            video <= level_b;
            hold(7'h42, dwell);
            hold(7'h02, SETTLE);
            ctrl_pins <= cia_ctrl_t'(7'h12);
            n = 0;
            // Bounded so a missing end of conversion cannot hang us
            while (serial_pin !== 1'b0 && n < 2000) begin
               @(posedge ref_clk);
               n++;
            end
            hold(7'h02, 4);
            // 64 ns shift period; 19th rise lets the converter release
            for (int i = 0; i < 19; i++) begin
               hold(7'h0a, 4);
               if (i < 18)
                  word = {word[16:0], serial_pin};
               hold(7'h02, 4);
            end
            pixel <= word;
            done <= 1'b1;
         end
      end
   end
endmodule // cia_ctrl_model

// ---- dv/cia_integrator_adc_tb.sv ----
// Bench for the integrator and converter model with a controller model.
// Assumes the design's own assertions cover its internal timing.
module cia_integrator_adc_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CONV = 10;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic start = 1'b0;
   logic [7:0] dwell = 8'h00;
   logic signed [15:0] level_a = 16'sh0000;
   logic signed [15:0] level_b = 16'sh0000;
   logic signed [15:0] video;
   cia_pkg::cia_ctrl_t ctrl;
   logic data_o, data_oe, busy, done;
   logic signed [23:0] integ;
   logic [17:0] pixel;
   wire logic serial_pin;
   int miscompares = 0;
   int checks = 0;
   int cycles = 0;
   int busy_cycles = 0;

   // Pull-up wins whenever the converter lets go
   assign serial_pin = data_oe ? data_o : 1'b1;

   cia_integrator_adc #(.CONV_CYCLES(CONV)) i_cia_integrator_adc (
      .ref_clk(ref_clk), .rst_n(rst_n), .ctrl_pins(ctrl),
      .video_sample(video), .serial_data_i(serial_pin),
      .serial_data_o(data_o), .serial_data_oe(data_oe),
      .integrator_out(integ), .conv_busy(busy));
   cia_ctrl_model i_cia_ctrl_model (
      .ref_clk(ref_clk), .rst_n(rst_n), .start(start), .dwell(dwell),
      .level_a(level_a), .level_b(level_b), .serial_pin(serial_pin),
      .ctrl_pins(ctrl), .video(video), .pixel(pixel), .done(done));

   // 125 MHz clock
   initial begin
      forever #4 ref_clk = ~ref_clk;
   end

   task automatic check(input logic [23:0] seen, input logic [23:0] exp,
                        input string what);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %s got %h expected %h", $time,
                  what, seen, exp);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Hang guard, conversion length and pin level while converting
   always @(posedge ref_clk) begin
      cycles++;
      if (busy === 1'b1) begin
         busy_cycles++;
         check(24'(serial_pin), 24'h000001, "pin in conversion");
      end
      if (cycles == 5000) begin
         miscompares++;
         end_sim();
      end
   end

   // One pixel; expected word is the net of both integrations
   task automatic run_pixel(input logic signed [15:0] ra,
                            input logic signed [15:0] sb, input int dw);
      int acc;
      int n;
      acc = dw * ra - dw * sb;
      level_a <= ra;
      level_b <= sb;
      dwell <= dw[7:0];
      busy_cycles = 0;
      start <= 1'b1;
      @(posedge ref_clk);
      start <= 1'b0;
      n = 0;
      @(posedge ref_clk);
      while (done !== 1'b1 && n < 2000) begin
         @(posedge ref_clk);
         n++;
      end
      check(24'(pixel), 24'(acc[17:0] ^ 18'h20000), "pixel");
      check(integ, acc[23:0], "integrator");
      check(busy_cycles[23:0], 24'(CONV), "conversion");
      check(24'(data_oe), 24'h000000, "pin release");
   endtask

   // Signal level below reset level leaves a positive residue
   task automatic test_signal();
      run_pixel(16'sh0064, 16'sh0032, 20);
      $display("test signal pixel done");
   endtask

   // Equal levels after a charged pixel: discharge must clear it
   task automatic test_equal();
      run_pixel(16'sh0064, 16'sh0064, 83);
      $display("test equal levels done");
   endtask

   // Negative residue checks offset binary coding
   task automatic test_negative();
      run_pixel(16'sh0005, 16'sh0008, 12);
      $display("test negative residue done");
   endtask

   // Main sequence
   initial begin
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      test_signal();
      test_equal();
      test_negative();
      end_sim();
   end
endmodule // cia_integrator_adc_tb
